// ===== i2cm_host.sv
// Purpose: bus host that writes, reads and polls a two-wire configuration slave
// Assumes: open-drain lines, enables low while pulling low, pull-ups outside
// Notes: one command at a time; a write with every byte acknowledged ends with acknowledge polling
// Summary of operation
// R1: start is data falling while clock is high
// R2: stop is data rising while clock is high, ends transaction
// R3: repeated start looks like start, without a stop before it
// R4: data changes only while clock low, stable during clock high
// R5: slave captures incoming bits on rising clock edge
// R6: slave changes its output bit on the falling edge before
// R7: every byte carries a ninth acknowledge bit with same timing
// R8: receiver pulls ninth bit low to acknowledge, leaves high to refuse
// R9: bytes are eight bits, most significant first, both directions
// R10: host acknowledges wanted bytes, refuses the last read byte
// R11: first byte after start holds seven-bit address and direction bit
// R12: address is fixed pattern with two bits from select pins
// R13: direction zero means write, one means read
// R14: slave ignores the bus after an unmatched address until start
// R15: second byte of a write is the memory location
// R16: single write is start, address, location, data, stop
// R17: slave refuses its address while programming after a write stop
// R18: host polls address until acknowledged or waits longest write time
// R19: single read uses location write, repeated start, read, refuse, stop
// R20: bus idle between stop and start with both lines high
// R21: host alone generates every clock pulse
// R22: slave only pulls data low and synchronises both lines; the slave model also holds the clock low when stretch is set
`timescale 1ns/1ps
module i2cm_host
    import i2cm_pkg::*;
#(
    parameter int QTR = QTR_CYC,
    parameter int NV_WAIT = NV_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic addr_select_bit0,
    input wire logic addr_select_bit1,
    input wire logic [7:0] cmd_mem,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_nack,
    output logic busy,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);
    logic scl_m_r;
    logic scl_s_r;
    logic sda_m_r;
    logic sda_s_r;
    logic tick;
    logic tick_en;

    i2cm_state_e st_r, st_nxt;
    i2cm_kind_e kind_r, kind_nxt;
    logic [1:0] op_r, op_nxt;
    logic [1:0] sel_r, sel_nxt;
    logic [7:0] mem_r, mem_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic [2:0] step_r, step_nxt;
    logic [1:0] q_r, q_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic nack_r, nack_nxt;
    logic poll_r, poll_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic scl_oe_n_r, scl_oe_n_nxt;
    logic sda_oe_n_r, sda_oe_n_nxt;
    logic cmd_ready_r, cmd_ready_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rsp_nack_r, rsp_nack_nxt;
    logic busy_r, busy_nxt;
    logic zero_r;

    // R16 R19 R18 byte sequence per command
    function automatic i2cm_kind_e step_kind(input logic [1:0] op, input logic poll, input logic [2:0] s);
        i2cm_kind_e k;
        k = K_END;
        if (poll || op == OP_POLL) begin
            case (s)
                3'h0: k = K_START;
                3'h1: k = K_WR;
                3'h2: k = K_STOP;
                default: k = K_END;
            endcase
        end else if (op == OP_WRITE) begin
            case (s)
                3'h0: k = K_START;
                3'h1, 3'h2, 3'h3: k = K_WR;
                3'h4: k = K_STOP;
                default: k = K_END;
            endcase
        end else begin
            case (s)
                3'h0, 3'h3: k = K_START;
                3'h1, 3'h2, 3'h4: k = K_WR;
                3'h5: k = K_RD;
                3'h6: k = K_STOP;
                default: k = K_END;
            endcase
        end
        return k;
    endfunction

    // R11 R12 R13 R15 byte contents per step
    function automatic logic [7:0] step_byte(input logic [2:0] s, input logic [1:0] sel,
                                             input logic [7:0] mem, input logic [7:0] wd);
        logic [7:0] b;
        b = 8'hff;
        case (s)
            3'h1: b = {ADDR_HI, sel, DIR_WRITE};
            3'h2: b = mem;
            3'h3: b = wd;
            3'h4: b = {ADDR_HI, sel, DIR_READ};
            default: b = 8'hff;
        endcase
        return b;
    endfunction

    function automatic logic [2:0] stop_step(input logic [1:0] op, input logic poll);
        logic [2:0] s;
        s = STOP_STEP_READ;
        if (poll || op == OP_POLL) begin
            s = STOP_STEP_POLL;
        end else if (op == OP_WRITE) begin
            s = STOP_STEP_WRITE;
        end
        return s;
    endfunction

    assign tick_en = (st_r == ST_START) || (st_r == ST_BYTE) || (st_r == ST_STOP);

    i2cm_tick #(.DIV(QTR)) u_tick (
        .clk(clk),
        .rstn(rstn),
        .en(tick_en),
        .tick(tick)
    );

    // pins cross into this domain through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
        end else begin
            scl_m_r <= scl_i;
            scl_s_r <= scl_m_r;
            sda_m_r <= sda_i;
            sda_s_r <= sda_m_r;
        end
    end

    always_comb begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        op_nxt = op_r;
        sel_nxt = sel_r;
        mem_nxt = mem_r;
        wd_nxt = wd_r;
        step_nxt = step_r;
        q_nxt = q_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        nack_nxt = nack_r;
        poll_nxt = poll_r;
        tmr_nxt = tmr_r;
        scl_oe_n_nxt = scl_oe_n_r;
        sda_oe_n_nxt = sda_oe_n_r;
        cmd_ready_nxt = 1'b0;
        rsp_valid_nxt = 1'b0;
        rdata_nxt = rdata_r;
        rsp_nack_nxt = rsp_nack_r;
        busy_nxt = 1'b1;
        if (poll_r && tmr_r < 32'(NV_WAIT)) begin
            tmr_nxt = tmr_r + 32'h1;
        end
        case (st_r)
            ST_IDLE: begin
                // R20 lines stay released while idle
                cmd_ready_nxt = 1'b1;
                busy_nxt = 1'b0;
                if (cmd_valid && cmd_ready_r) begin
                    cmd_ready_nxt = 1'b0;
                    busy_nxt = 1'b1;
                    op_nxt = cmd_op;
                    sel_nxt = {addr_select_bit1, addr_select_bit0};
                    mem_nxt = cmd_mem;
                    wd_nxt = cmd_wdata;
                    step_nxt = 3'h0;
                    nack_nxt = 1'b0;
                    poll_nxt = 1'b0;
                    tmr_nxt = 32'h0;
                    st_nxt = ST_SEQ;
                end
            end
            ST_SEQ: begin
                kind_nxt = step_kind(op_r, poll_r, step_r);
                q_nxt = 2'h0;
                bit_nxt = 4'h0;
                case (step_kind(op_r, poll_r, step_r))
                    K_START: st_nxt = ST_START;
                    K_WR: begin
                        sh_nxt = step_byte(step_r, sel_r, mem_r, wd_r);
                        st_nxt = ST_BYTE;
                    end
                    K_RD: begin
                        sh_nxt = 8'hff;
                        st_nxt = ST_BYTE;
                    end
                    K_STOP: st_nxt = ST_STOP;
                    default: begin
                        // R17 R18 poll the address after a write until taken or time is up
                        if (op_r == OP_WRITE && !poll_r && !nack_r) begin
                            poll_nxt = 1'b1;
                            tmr_nxt = 32'h0;
                            step_nxt = 3'h0;
                        end else if (poll_r && nack_r && tmr_r < 32'(NV_WAIT)) begin
                            nack_nxt = 1'b0;
                            step_nxt = 3'h0;
                        end else begin
                            rsp_valid_nxt = 1'b1;
                            rsp_nack_nxt = nack_r;
                            poll_nxt = 1'b0;
                            st_nxt = ST_IDLE;
                        end
                    end
                endcase
            end
            ST_START: begin
                // R1 R3 start and repeated start share one sequence
                if (tick) begin
                    case (q_r)
                        2'h0: begin
                            sda_oe_n_nxt = 1'b1;
                            q_nxt = 2'h1;
                        end
                        2'h1: begin
                            scl_oe_n_nxt = 1'b1;
                            q_nxt = 2'h2;
                        end
                        2'h2: begin
                            if (scl_s_r && sda_s_r) begin
                                sda_oe_n_nxt = 1'b0;
                                q_nxt = 2'h3;
                            end
                        end
                        default: begin
                            scl_oe_n_nxt = 1'b0;
                            step_nxt = step_r + 3'h1;
                            st_nxt = ST_SEQ;
                        end
                    endcase
                end
            end
            ST_BYTE: begin
                if (tick) begin
                    case (q_r)
                        2'h0: begin
                            // R4 R9 R7 R8 R10 set data while clock is low, msb first
                            if (bit_r == ACK_BIT || kind_r == K_RD) begin
                                sda_oe_n_nxt = 1'b1;
                            end else begin
                                sda_oe_n_nxt = sh_r[7];
                            end
                            q_nxt = 2'h1;
                        end
                        2'h1: begin
                            // R21 host makes the clock pulse
                            scl_oe_n_nxt = 1'b1;
                            q_nxt = 2'h2;
                        end
                        2'h2: begin
                            // R6 slave bit is valid by this high phase
                            if (scl_s_r) begin
                                if (bit_r != ACK_BIT) begin
                                    sh_nxt = {sh_r[6:0], sda_s_r};
                                end else if (kind_r == K_WR) begin
                                    nack_nxt = sda_s_r;
                                end
                                q_nxt = 2'h3;
                            end
                        end
                        default: begin
                            scl_oe_n_nxt = 1'b0;
                            q_nxt = 2'h0;
                            if (bit_r == ACK_BIT) begin
                                st_nxt = ST_SEQ;
                                if (kind_r == K_RD) begin
                                    rdata_nxt = sh_r;
                                end
                                // R14 a refused byte ends the transfer with a stop
                                if (nack_r) begin
                                    step_nxt = stop_step(op_r, poll_r);
                                end else begin
                                    step_nxt = step_r + 3'h1;
                                end
                            end else begin
                                bit_nxt = bit_r + 4'h1;
                            end
                        end
                    endcase
                end
            end
            ST_STOP: begin
                // R2 data rises while clock is high
                if (tick) begin
                    case (q_r)
                        2'h0: begin
                            sda_oe_n_nxt = 1'b0;
                            q_nxt = 2'h1;
                        end
                        2'h1: begin
                            scl_oe_n_nxt = 1'b1;
                            q_nxt = 2'h2;
                        end
                        2'h2: begin
                            if (scl_s_r) begin
                                sda_oe_n_nxt = 1'b1;
                                q_nxt = 2'h3;
                            end
                        end
                        default: begin
                            step_nxt = step_r + 3'h1;
                            st_nxt = ST_SEQ;
                        end
                    endcase
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= ST_IDLE;
            kind_r <= K_END;
            op_r <= 2'h0;
            sel_r <= 2'h0;
            mem_r <= 8'h00;
            wd_r <= 8'h00;
            step_r <= 3'h0;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            nack_r <= 1'b0;
            poll_r <= 1'b0;
            tmr_r <= 32'h0;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
            cmd_ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rdata_r <= 8'h00;
            rsp_nack_r <= 1'b0;
            busy_r <= 1'b0;
            zero_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            op_r <= op_nxt;
            sel_r <= sel_nxt;
            mem_r <= mem_nxt;
            wd_r <= wd_nxt;
            step_r <= step_nxt;
            q_r <= q_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            nack_r <= nack_nxt;
            poll_r <= poll_nxt;
            tmr_r <= tmr_nxt;
            scl_oe_n_r <= scl_oe_n_nxt;
            sda_oe_n_r <= sda_oe_n_nxt;
            cmd_ready_r <= cmd_ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rdata_r <= rdata_nxt;
            rsp_nack_r <= rsp_nack_nxt;
            busy_r <= busy_nxt;
            zero_r <= 1'b0;
        end
    end

    assign scl_o = zero_r;
    assign sda_o = zero_r;
    assign scl_oe_n = scl_oe_n_r;
    assign sda_oe_n = sda_oe_n_r;
    assign cmd_ready = cmd_ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rdata_r;
    assign rsp_nack = rsp_nack_r;
    assign busy = busy_r;

    property p_start;
        @(posedge clk) disable iff (!rstn) $fell(sda_oe_n_r) && scl_oe_n_r |-> st_r == ST_START;
    endproperty
    a_start: assert property (p_start) else $error("data pulled low with clock high outside start"); // R1

    property p_stop;
        @(posedge clk) disable iff (!rstn) $rose(sda_oe_n_r) && scl_oe_n_r |-> $past(st_r) == ST_STOP;
    endproperty
    a_stop: assert property (p_stop) else $error("data released with clock high outside stop"); // R2

    property p_data_stable;
        @(posedge clk) disable iff (!rstn) st_r == ST_BYTE && scl_oe_n_r && $past(scl_oe_n_r) |-> $stable(sda_oe_n_r);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved during clock high"); // R4

    property p_ack_release;
        @(posedge clk) disable iff (!rstn) st_r == ST_BYTE && bit_r == ACK_BIT && q_r != 2'h0 |-> sda_oe_n_r;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("host drove the ninth bit low"); // R10

    property p_addr_byte;
        @(posedge clk) disable iff (!rstn)
            st_r == ST_BYTE && $past(st_r) == ST_SEQ && (step_r == 3'h1 || step_r == 3'h4) && kind_r == K_WR
            |-> sh_r == {ADDR_HI, sel_r, step_r == 3'h4};
    endproperty
    a_addr_byte: assert property (p_addr_byte) else $error("wrong address byte after start"); // R12

    property p_msb_first;
        @(posedge clk) disable iff (!rstn)
            tick && st_r == ST_BYTE && q_r == 2'h0 && kind_r == K_WR && bit_r != ACK_BIT
            |=> sda_oe_n_r == $past(sh_r[7]) ##1 sda_oe_n_r == $past(sh_r[7], 2);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("data bit not taken from msb"); // R9

    property p_idle_lines;
        @(posedge clk) disable iff (!rstn) cmd_ready_r |-> scl_oe_n_r && sda_oe_n_r && !busy_r;
    endproperty
    a_idle_lines: assert property (p_idle_lines) else $error("lines not released while idle"); // R20

    property p_clock_rise;
        @(posedge clk) disable iff (!rstn) $rose(scl_oe_n_r) |-> $past(q_r) == 2'h1 && $past(tick);
    endproperty
    a_clock_rise: assert property (p_clock_rise) else $error("clock released off the quarter schedule"); // R21

    property p_rsp_pulse;
        @(posedge clk) disable iff (!rstn) rsp_valid_r |=> !rsp_valid_r && cmd_ready_r;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("response not a single pulse"); // R18
endmodule // i2cm_host

// ===== i2cm_pkg.sv
// Purpose: shared constants and types for the two-wire bus host controller
// Assumes: 100 MHz system clock, open-drain bus lines with external pull-ups
// Notes: times are kept in their own units; cycle counts derive from them
package i2cm_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYC = (SCL_PERIOD_NS / 4) / CLK_PERIOD_NS;
    localparam int NV_WRITE_TIME_US = 20;
    localparam int NV_WAIT_CYC = (NV_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // fixed upper part of the slave address, low two bits come from the select inputs
    localparam logic [4:0] ADDR_HI = 5'h14;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [2:0] STOP_STEP_POLL = 3'h2;
    localparam logic [2:0] STOP_STEP_WRITE = 3'h4;
    localparam logic [2:0] STOP_STEP_READ = 3'h6;

    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_READ = 2'b01,
        OP_POLL = 2'b10
    } i2cm_op_e;

    typedef enum logic [2:0] {
        K_START = 3'b000,
        K_WR = 3'b001,
        K_RD = 3'b010,
        K_STOP = 3'b011,
        K_END = 3'b100
    } i2cm_kind_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEQ = 3'b001,
        ST_START = 3'b010,
        ST_BYTE = 3'b011,
        ST_STOP = 3'b100
    } i2cm_state_e;

endpackage

// ===== i2cm_tick.sv
// Purpose: quarter-bit enable pulse for the serial clock
// Assumes: counter held cleared while not enabled
// Notes: first pulse comes DIV cycles after enable rises
`timescale 1ns/1ps
module i2cm_tick
    import i2cm_pkg::*;
#(
    parameter int DIV = QTR_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic en,
    output logic tick
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!en) begin
            cnt_nxt = 16'h0000;
        end else if (cnt_r == 16'(DIV - 1)) begin
            cnt_nxt = 16'h0000;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule // i2cm_tick

// ===== i2cm_dev_model.sv
// Purpose: behavioural two-wire configuration slave facing the host
// Assumes: wires resolved outside with pull-ups
// Notes: optional clock hold after each falling edge, optional data refusal
`timescale 1ns/1ps
module i2cm_dev_model
    import i2cm_pkg::*;
#(
    parameter int NV_CYC = 300
) (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic addr_select_bit0,
    input wire logic addr_select_bit1,
    input wire logic nack_data,
    input wire logic [3:0] stretch,
    output logic scl_oe_n,
    output logic sda_oe_n
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic act, mack, wrote, rd, hit;
    int bitn, phase, nv, addr_nacks;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'ha5;
        {scl_oe_n, sda_oe_n, act, wrote} = 4'b1100;
        {nv, addr_nacks, bitn, phase} = {32'd0, 32'd0, 32'd0, 32'd0};
    end
    always @(posedge clk) if (nv > 0) nv = nv - 1;
    always @(negedge sda) if (scl === 1'b1) begin
        {act, sda_oe_n} = 2'b11;
        {bitn, phase} = {32'd0, 32'd0};
    end
    // stop ends transfer, arms programming time after a stored write
    always @(posedge sda) if (scl === 1'b1) begin
        {act, sda_oe_n} = 2'b01;
        if (wrote) nv = NV_CYC;
        wrote = 1'b0;
    end
    always @(posedge scl) if (act) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        else mack = sda;
        bitn++;
    end
    always @(negedge scl) if (act) begin
        if (bitn == 8 && phase != 3) begin
            if (phase == 0) begin
                hit = sh[7:1] == {ADDR_HI, addr_select_bit1, addr_select_bit0};
                if (hit && nv > 0) addr_nacks++;
                act = hit && nv == 0;
                rd = sh[0];
            end else if (phase == 1) ptr = sh;
            else begin
                act = !nack_data;
                if (act) begin
                    mem[ptr] = sh;
                    ptr++;
                    wrote = 1'b1;
                end
            end
            sda_oe_n = !act;
        end else if (bitn == 9) begin
            bitn = 0;
            if (phase == 3) act = !mack;
            else phase = (phase == 0) ? (rd ? 3 : 1) : 2;
            sda_oe_n = (act && phase == 3) ? mem[ptr][7] : 1'b1;
        end else if (phase == 3) begin
            sda_oe_n = (bitn < 8) ? mem[ptr][7 - bitn] : 1'b1;
            if (bitn == 8) ptr++;
        end
    end
    // slow answer: hold the clock low a while
    always @(negedge scl) if (stretch != 4'h0) begin
        scl_oe_n = 1'b0;
        repeat (stretch) @(posedge clk);
        scl_oe_n = 1'b1;
    end
endmodule // i2cm_dev_model

// ===== i2cm_host_tb.sv
// Purpose: self-checking bench for the two-wire host
// Assumes: shortened quarter and wait counts
// Notes: wires resolved as wired-and with pull-ups
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module i2cm_host_tb
    import i2cm_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'b00;
    logic [1:0] host_sel = 2'b00;
    logic [7:0] cmd_mem = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic [1:0] dev_sel = 2'b01;
    logic nack_data = 1'b0;
    logic [3:0] stretch = 4'h0;
    logic cmd_ready, rsp_valid, rsp_nack, busy, scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl_oe_n, m_sda_oe_n;
    logic [7:0] rsp_rdata;
    int failures = 0;
    int cmp_count = 0;
    int n_start = 0;
    int n_stop = 0;
    wire scl_w = scl_oe_n & m_scl_oe_n;
    wire sda_w = sda_oe_n & m_sda_oe_n;
    always #5 clk = ~clk;
    always @(negedge sda_w) if (scl_w) n_start++;
    always @(posedge sda_w) if (scl_w) n_stop++;
    i2cm_host #(.QTR(4), .NV_WAIT(1000)) dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .addr_select_bit0(host_sel[0]), .addr_select_bit1(host_sel[1]), .cmd_mem(cmd_mem), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack), .busy(busy),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    i2cm_dev_model #(.NV_CYC(300)) dev (.clk(clk), .scl(scl_w), .sda(sda_w), .addr_select_bit0(dev_sel[0]),
        .addr_select_bit1(dev_sel[1]), .nack_data(nack_data), .stretch(stretch), .scl_oe_n(m_scl_oe_n),
        .sda_oe_n(m_sda_oe_n));
    task automatic give_verdict;
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic do_cmd(input logic [1:0] op, input logic [1:0] sel, input logic [7:0] m, input logic [7:0] d);
        int n;
        logic rdy;
        n = 0;
        @(posedge clk);
        {cmd_valid, cmd_op, host_sel, cmd_mem, cmd_wdata} <= {1'b1, op, sel, m, d};
        {n_start, n_stop} = {32'd0, 32'd0};
        do begin
            #1 rdy = cmd_ready;
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (rsp_valid !== 1'b1 && n < 20000);
        if (rsp_valid !== 1'b1) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic t_wr_rd(input logic [7:0] m, input logic [7:0] d);
        int nacks;
        nacks = dev.addr_nacks;
        do_cmd(OP_WRITE, dev_sel, m, d);
        `CHK("write nack", 1'b0, rsp_nack)
        `CHK("stored", d, dev.mem[m])
        `CHK("polled busy", 1'b1, dev.addr_nacks > nacks)
        `CHK("busy at answer", 1'b1, busy)
        `CHK("clock pull level", 1'b0, scl_o)
        `CHK("data pull level", 1'b0, sda_o)
        do_cmd(OP_READ, dev_sel, m, 8'h00);
        `CHK("read data", d, rsp_rdata)
        `CHK("read nack", 1'b0, rsp_nack)
        `CHK("starts", 2, n_start)
        `CHK("stops", 1, n_stop)
        @(posedge clk);
        #1;
        `CHK("idle busy", 1'b0, busy)
        `CHK("idle ready", 1'b1, cmd_ready)
    endtask
    task automatic t_select;
        for (int s = 0; s < 4; s++) begin
            do_cmd(OP_POLL, s[1:0], 8'h00, 8'h00);
            `CHK("poll nack", s[1:0] != dev_sel, rsp_nack)
            `CHK("poll starts", 1, n_start)
        end
        do_cmd(OP_WRITE, 2'b10, 8'h33, 8'h77);
        `CHK("foreign nack", 1'b1, rsp_nack)
        `CHK("foreign ignored", 8'h33 ^ 8'ha5, dev.mem[8'h33])
    endtask
    task automatic t_refuse;
        @(posedge clk);
        nack_data <= 1'b1;
        do_cmd(OP_WRITE, dev_sel, 8'h44, 8'h99);
        `CHK("data refused", 1'b1, rsp_nack)
        `CHK("not stored", 8'h44 ^ 8'ha5, dev.mem[8'h44])
        @(posedge clk);
        nack_data <= 1'b0;
        do_cmd(OP_POLL, dev_sel, 8'h00, 8'h00);
        `CHK("no programming", 1'b0, rsp_nack)
    endtask
    initial begin
        repeat (12) @(posedge clk);
        `CHK("idle lines", 2'b11, {scl_w, sda_w})
        rstn <= 1'b1;
        t_wr_rd(8'h00, 8'h80);
        t_select;
        t_refuse;
        @(posedge clk);
        // hold longer than two quarters so the host really waits on the clock line
        {stretch, dev_sel} <= {4'hc, 2'b10};
        @(posedge clk);
        t_wr_rd(8'hff, 8'h01);
        give_verdict();
    end
endmodule // i2cm_host_tb
